/* File: logic/dgfc_pkg.sv */
// shared constants and types for the gated frequency and duty counter
package dgfc_pkg;

  localparam int REF_W  = 24;
  localparam int PRE_W  = 16;
  localparam int LOW_W  = 8;
  localparam int GATE_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_REFCNT = 8'h08;
  localparam logic [7:0] OFS_INCNT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQEN  = 8'h14;

  // control field positions
  localparam int CTRL_SRC_BIT  = 0;
  localparam int CTRL_DIV_BIT  = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_ARM_BIT  = 4;
  localparam int CTRL_LOAD_BIT = 5;
  localparam int CTRL_GIE_BIT  = 6;

  // preset field positions
  localparam int PRESET_GATE_LSB = 16;

  // status field positions
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_LEVEL_BIT = 5;

  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [2:0]  GATE_RESET   = 3'h0;

  // reference clock divide counts, one tick every n plus one main clocks
  localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0] DIV_FAST_LAST = 2'h1;

  typedef enum logic [1:0] {
    MODE_FREQ  = 2'b00,
    MODE_DUTY  = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_FREQ2 = 2'b11
  } dgfc_mode_e;

  // gray codes along idle, wait, run, overflowed, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_RUN  = 3'b011,
    ST_OVF  = 3'b010,
    ST_DONE = 3'b110
  } dgfc_state_e;

  typedef struct packed {
    logic       globalIrqEn;
    logic       preloadStrobe;
    logic       countArm;
    dgfc_mode_e measureModeSel;
    logic       refClockDivSel;
    logic       inputSourceSel;
  } dgfc_ctrl_s;

  typedef struct packed {
    logic [PRE_W-1:0] upper;
    logic [LOW_W-1:0] lower;
  } dgfc_refcnt_s;

endpackage

/* File: logic/dgfc_pin_sync.sv */
// three-stage synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module dgfc_pin_sync
  import dgfc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstSyncN,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output var  logic level,
  output var  logic rise
);

  logic stage1Reg;
  logic stage2Reg;
  logic stage3Reg;
  logic levelReg;
  logic riseReg;
  logic levelNext;
  logic riseNext;

  // a change only counts once the second and third stages agree
  always_comb
  begin
    levelNext = levelReg;
    if (stage2Reg == stage3Reg)
    begin
      levelNext = stage3Reg;
    end
    riseNext = levelNext & ~levelReg;
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
      levelReg  <= 1'b0;
      riseReg   <= 1'b0;
    end
    else if (clkEn)
    begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      levelReg  <= levelNext;
      riseReg   <= riseNext;
    end
  end

  assign level = levelReg;
  assign rise  = riseReg;

endmodule
`default_nettype wire

/* File: logic/dgfc_counter_pair.sv */
// dual 24-bit gated frequency, duty and timer counter with apb registers
//
// Notes on behaviour
// RQ1: reference tick is main clock divided by four, or by two when selected.
// RQ2: preset write under preload loads counter bits 23..8 and gate length together.
// RQ3: frequency and duty runs start on the first measured rising edge after arming.
// RQ4: they run past reference overflow, stop at the next rising edge, then interrupt.
// RQ5: timer mode starts on arming and stops with interrupt at reference overflow.
// RQ6: host preloads with arm low, then writes preset and gate length together.
// RQ7: gate 000 gives a full 24-bit count, gate 111 a 17-bit count.
// RQ8: gate codes in between carry from bit seven minus code into the upper part.
// RQ9: with gate 000 the window is (1000000h minus preset times 256) ticks.
// RQ10: frequency mode counts ticks and input cycles; both stay readable afterwards.
// RQ11: duty mode counts ticks only while the measured input is high.
// RQ12: host computes frequency from tick rate, input count and preset plus count.
// RQ13: host computes duty as input count over inverted preset plus count.
// RQ14: measured input is the comparator when source select is one, else the pin.
// RQ15: completion latches a pending flag, gated by its enable and global enable.
`timescale 1ns/1ps
`default_nettype none
module dgfc_counter_pair
  import dgfc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        comparatorResult,
  input  wire logic        counterPinInput,
  output var  logic        irq
);

  function automatic logic addrMapped(input logic [7:0] a);
    addrMapped = (a == OFS_CTRL) || (a == OFS_PRESET) || (a == OFS_REFCNT)
              || (a == OFS_INCNT) || (a == OFS_STATUS) || (a == OFS_IRQEN);
  endfunction

  logic rstMetaReg;
  logic rstSyncN;

  // release is synchronised so no flop leaves reset on a ragged edge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMetaReg <= 1'b0;
      rstSyncN   <= 1'b0;
    end
    else
    begin
      rstMetaReg <= 1'b1;
      rstSyncN   <= rstMetaReg;
    end
  end

  dgfc_ctrl_s            ctrl_reg;
  dgfc_ctrl_s            ctrl_next;
  logic [PRE_W-1:0]      preset_reg;
  logic [PRE_W-1:0]      preset_next;
  logic [GATE_W-1:0]     gate_reg;
  logic [GATE_W-1:0]     gate_next;
  logic                  pending_reg;
  logic                  pending_next;
  logic                  irqEn_reg;
  logic                  irqEn_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  logic [1:0]            div_reg;
  logic [1:0]            div_next;
  dgfc_state_e           state_reg;
  dgfc_state_e           state_next;
  dgfc_refcnt_s          refCnt_reg;
  dgfc_refcnt_s          refCnt_next;
  logic [REF_W-1:0]      inCnt_reg;
  logic [REF_W-1:0]      inCnt_next;

  logic measuredRaw;
  logic measuredLevel;
  logic measuredRise;
  logic refTick;
  logic setupPhase;
  logic writeAccess;
  logic presetLoad;
  logic doneEvent;
  logic refOverflow;
  logic lowCarry;
  logic [LOW_W-1:0] lowMask;
  logic isTimer;
  logic counting;

  // RQ14: source select mux
  assign measuredRaw = ctrl_reg.inputSourceSel ? comparatorResult : counterPinInput;

  dgfc_pin_sync u_sync (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .clkEn    (clkEn),
    .pinIn    (measuredRaw),
    .level    (measuredLevel),
    .rise     (measuredRise)
  );

  // RQ1: reference tick divider
  always_comb
  begin
    div_next = div_reg + 2'h1;
    refTick  = 1'b0;
    if (div_reg == (ctrl_reg.refClockDivSel ? DIV_FAST_LAST : DIV_SLOW_LAST))
    begin
      refTick  = 1'b1;
      div_next = 2'h0;
    end
  end

  assign setupPhase  = psel & ~penable;
  assign writeAccess = psel & penable & pwrite & clkEn;
  // RQ2: preset load only while preload strobe is set
  assign presetLoad  = writeAccess && (paddr == OFS_PRESET) && ctrl_reg.preloadStrobe;

  assign isTimer  = (ctrl_reg.measureModeSel == MODE_TIMER);
  assign counting = (state_reg == ST_RUN) || (state_reg == ST_OVF);

  // RQ7: gate code picks the carry bit of the lower byte
  // RQ8: intermediate codes carry from bit seven minus the code
  assign lowMask     = 8'hFF >> gate_reg;
  assign lowCarry    = refTick && ((refCnt_reg.lower & lowMask) == lowMask);
  // RQ9: window ends when the preset-loaded upper part wraps
  assign refOverflow = counting && lowCarry && (&refCnt_reg.upper);

  // counter state machine
  always_comb
  begin
    state_next  = state_reg;
    refCnt_next = refCnt_reg;
    inCnt_next  = inCnt_reg;
    doneEvent   = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (ctrl_reg.countArm && !ctrl_reg.preloadStrobe)
        begin
          // RQ5: timer starts at once
          // RQ3: measuring modes wait for an edge
          state_next = isTimer ? ST_RUN : ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (measuredRise)
        begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (refOverflow)
        begin
          // RQ5: timer stops at overflow
          // RQ4: measuring modes keep running
          state_next = isTimer ? ST_DONE : ST_OVF;
          doneEvent  = isTimer;
        end
      end
      ST_OVF:
      begin
        // RQ4: stop on the edge after overflow
        if (measuredRise)
        begin
          state_next = ST_DONE;
          doneEvent  = 1'b1;
        end
      end
      ST_DONE:
      begin
        state_next = ST_DONE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    if (!ctrl_reg.countArm)
    begin
      state_next = ST_IDLE;
      doneEvent  = 1'b0;
    end
    // RQ10: reference counter counts ticks in the window
    if (counting && refTick)
    begin
      refCnt_next.lower = refCnt_reg.lower + 8'h01;
      if (lowCarry)
      begin
        refCnt_next.upper = refCnt_reg.upper + 16'h0001;
      end
    end
    if (counting)
    begin
      if (ctrl_reg.measureModeSel == MODE_DUTY)
      begin
        // RQ11: high time in reference ticks
        if (refTick && measuredLevel)
        begin
          inCnt_next = inCnt_reg + 24'h00_0001;
        end
      end
      // RQ10: input cycles counted on rising edges
      else if (measuredRise)
      begin
        inCnt_next = inCnt_reg + 24'h00_0001;
      end
    end
    // RQ2: preset lands in the upper part, counts restart from it
    if (presetLoad)
    begin
      refCnt_next.upper = pwdata[PRE_W-1:0];
      refCnt_next.lower = 8'h00;
      inCnt_next        = 24'h00_0000;
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_reg  <= ST_IDLE;
      refCnt_reg <= '0;
      inCnt_reg  <= '0;
      div_reg    <= 2'h0;
    end
    else if (clkEn)
    begin
      state_reg  <= state_next;
      refCnt_reg <= refCnt_next;
      inCnt_reg  <= inCnt_next;
      div_reg    <= div_next;
    end
  end

  // register file
  always_comb
  begin
    ctrl_next    = ctrl_reg;
    preset_next  = preset_reg;
    gate_next    = gate_reg;
    irqEn_next   = irqEn_reg;
    pending_next = pending_reg;
    rdata_next   = rdata_reg;
    if (writeAccess)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          ctrl_next = pwdata[$bits(dgfc_ctrl_s)-1:0];
        end
        OFS_IRQEN:
        begin
          irqEn_next = pwdata[STAT_DONE_BIT];
        end
        OFS_STATUS:
        begin
          if (pwdata[STAT_DONE_BIT])
          begin
            pending_next = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // RQ2: gate length updated with the preset
    if (presetLoad)
    begin
      preset_next = pwdata[PRE_W-1:0];
      gate_next   = pwdata[PRESET_GATE_LSB +: GATE_W];
    end
    // RQ15: completion sets pending, set wins over clear
    if (doneEvent)
    begin
      pending_next = 1'b1;
    end
    // read data captured in setup so it stands for the access phase
    if (setupPhase)
    begin
      rdata_next = 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL:
        begin
          rdata_next[$bits(dgfc_ctrl_s)-1:0] = ctrl_reg;
        end
        OFS_PRESET:
        begin
          rdata_next[PRE_W-1:0]                  = preset_reg;
          rdata_next[PRESET_GATE_LSB +: GATE_W] = gate_reg;
        end
        OFS_REFCNT:
        begin
          rdata_next[REF_W-1:0] = refCnt_reg;
        end
        OFS_INCNT:
        begin
          rdata_next[REF_W-1:0] = inCnt_reg;
        end
        OFS_STATUS:
        begin
          rdata_next[STAT_DONE_BIT]       = pending_reg;
          rdata_next[STAT_STATE_LSB +: 3] = state_reg;
          rdata_next[STAT_LEVEL_BIT]      = measuredLevel;
        end
        OFS_IRQEN:
        begin
          rdata_next[STAT_DONE_BIT] = irqEn_reg;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      ctrl_reg    <= CTRL_RESET[$bits(dgfc_ctrl_s)-1:0];
      preset_reg  <= PRESET_RESET;
      gate_reg    <= GATE_RESET;
      irqEn_reg   <= 1'b0;
      pending_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ctrl_reg    <= ctrl_next;
      preset_reg  <= preset_next;
      gate_reg    <= gate_next;
      irqEn_reg   <= irqEn_next;
      pending_reg <= pending_next;
      rdata_reg   <= rdata_next;
    end
  end

  // zero wait states; a frozen clock enable would stall a multi-cycle answer
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrMapped(paddr);
  assign prdata  = rdata_reg;

  // RQ15: level interrupt, gated by enable and global enable
  assign irq = pending_reg & irqEn_reg & ctrl_reg.globalIrqEn;

endmodule
`default_nettype wire

/* File: dv/dgfc_asserts.sv */
// port assertions for the gated counter pair
`timescale 1ns/1ps
`default_nettype none
module dgfc_asserts
  import dgfc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comparatorResult,
  input wire logic        counterPinInput,
  input wire logic        irq
);
  logic [31:0] ctrlSh;
  logic [15:0] preSh;
  logic [7:0]  since;
  logic        enSh, fresh, lastIn;
  wire         acc = psel && penable && clkEn;
  wire         wrAcc = acc && pwrite;
  wire         setup = psel && !penable && clkEn;
  wire         mapped = paddr[1:0] == 2'b00 && paddr <= OFS_IRQEN;
  wire         gateOn = enSh && ctrlSh[CTRL_GIE_BIT];
  wire         selIn = ctrlSh[CTRL_SRC_BIT] ? comparatorResult : counterPinInput;
  // shadow of software writes; since counts cycles after a raw rise of the chosen input
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlSh <= 32'h0000_0000;
      preSh <= 16'h0000;
      enSh <= 1'b0;
      fresh <= 1'b0;
      lastIn <= 1'b0;
      since <= 8'hff;
    end
    else
    begin
      lastIn <= selIn;
      since <= (selIn && !lastIn) ? 8'h00 : since + {7'h00, since != 8'hff};
      if (wrAcc && paddr == OFS_CTRL)
        ctrlSh <= pwdata;
      if (wrAcc && paddr == OFS_IRQEN)
        enSh <= pwdata[0];
      if (wrAcc && paddr == OFS_CTRL && pwdata[CTRL_ARM_BIT])
        fresh <= 1'b0;
      if (wrAcc && paddr == OFS_PRESET && ctrlSh[CTRL_LOAD_BIT])
      begin
        preSh <= pwdata[15:0];
        fresh <= 1'b1;
      end
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_err_decode: assert property (acc |-> pslverr == !mapped)
    else $error("error flag disagrees with decode");
  chk_read_hold: assert property (!$past(setup) |-> $stable(prdata))
    else $error("read data moved outside a setup edge");
  chk_preset_load: assert property (acc && !pwrite && paddr == OFS_REFCNT && fresh
    |-> prdata[23:0] == {preSh, 8'h00})
    else $error("preset not loaded into upper count");
  chk_irq_gated: assert property (irq |-> gateOn)
    else $error("interrupt without both enables");
  chk_irq_sticky: assert property (irq && !wrAcc |=> irq)
    else $error("interrupt dropped by itself");
  chk_irq_clear: assert property (wrAcc && paddr == OFS_STATUS && pwdata[0] |=> !irq)
    else $error("interrupt survived a clear");
  chk_done_armed: assert property ($rose(irq) && $past(gateOn) |-> ctrlSh[CTRL_ARM_BIT])
    else $error("completion while not armed");
  chk_stop_edge: assert property ($rose(irq) && $past(gateOn) && ctrlSh[3:2] != 2'b10
    |-> since <= 8'd10)
    else $error("measurement stopped away from an input rise");
endmodule

bind dgfc_counter_pair dgfc_asserts chk (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .comparatorResult(comparatorResult), .counterPinInput(counterPinInput));
`default_nettype wire

/* File: dv/dgfc_pulse_src.sv */
// measured signal source standing on the pin or comparator side
`timescale 1ns/1ps
`default_nettype none
module dgfc_pulse_src
(
  input  wire logic mclk,
  input  wire logic en,
  input  wire logic srcSel,
  input  var  int   period,
  input  var  int   highTime,
  output var  logic pinOut,
  output var  logic cmpOut
);
  int   phase;
  logic wave;
  // pulses start high at enable, so the first rise is at a known edge
  assign wave = en && (phase < highTime);
  // only the selected line carries pulses, the other rests low
  assign pinOut = wave && !srcSel;
  assign cmpOut = wave && srcSel;
  always_ff @(posedge mclk)
    phase <= (!en || phase >= period - 1) ? 0 : phase + 1;
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the gated counter pair
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dgfc_pkg::*;
;
  logic        mclk, reset_n, psel, penable, pwrite, pin, cmp, irq;
  logic        pready, pslverr, lastErr, pulseEn, srcSel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  int          errors, total_checks, cycles, period, highTime;

  dgfc_counter_pair uut (.mclk(mclk), .reset_n(reset_n), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparatorResult(cmp), .counterPinInput(pin),
    .irq(irq));
  dgfc_pulse_src partner (.mclk(mclk), .en(pulseEn), .srcSel(srcSel), .period(period),
    .highTime(highTime), .pinOut(pin), .cmpOut(cmp));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic final_report;
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // the whole sequence needs about six thousand cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic near(input logic [31:0] got, input int e, input int tol);
    return got + tol >= e && got <= e + tol;
  endfunction

  // reference count after t ticks: low byte always counts, upper on masked carry
  function automatic int refModel(input int p, input int g, input int t);
    int lo;
    int up;
    lo = 0;
    up = p;
    for (int i = 0; i < t; i++)
    begin
      if ((lo & (255 >> g)) == (255 >> g))
        up = (up + 1) & 65535;
      lo = (lo + 1) & 255;
    end
    return up * 256 + lo;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input int d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic run(input int mode, input int g, input int div, input int src, input int p);
    int base, t, d, k, n, win, cnt, span;
    base = src + 2 * div + 4 * mode + 64;
    d = div ? 2 : 4;
    t = (65536 - p) * (256 >> g);
    // the partner puts pulses on the line that is selected
    srcSel <= src[0];
    // preload with arm low, then preset and gate length together
    apb(1, OFS_CTRL, base + 32);
    apb(1, OFS_PRESET, p + (g << 16));
    apb(0, OFS_REFCNT, 0);
    check(rd, p * 256);
    apb(1, OFS_IRQEN, 1);
    apb(1, OFS_CTRL, base + 16);
    if (mode != 2)
    begin
      repeat (16) @(posedge mclk);
      apb(0, OFS_REFCNT, 0);
      check(rd, p * 256);
      pulseEn <= 1'b1;
    end
    n = 0;
    while (irq !== 1'b1 && n < 20000)
    begin
      @(posedge mclk);
      n++;
    end
    pulseEn <= 1'b0;
    check(irq, 1);
    k = mode == 2 ? 0 : t * d / period + 1;
    win = mode == 2 ? t * d : k * period;
    check(near(n, mode == 2 ? win - 1 : win + 5, 5), 1);
    // host turns these two counts into frequency or duty
    apb(0, OFS_INCNT, 0);
    cnt = rd;
    check(near(rd, mode == 1 ? k * highTime / d : k, mode == 1 ? 2 : 0), 1);
    t = mode == 2 ? t : win / d;
    apb(0, OFS_REFCNT, 0);
    check(rd === refModel(p, g, t - 1) || rd === refModel(p, g, t) ||
          rd === refModel(p, g, t + 1), 1);
    if (g == 0 && mode != 2)
    begin
      // host span: inverted preset plus final count, only meaningful for the full gate
      span = 16777215 - p * 256 + rd[23:0];
      if (mode == 1)
        check(near(100 * cnt / span, 100 * highTime / period, 2), 1);
      else
        check(near(span * d / cnt, period, 1), 1);
    end
    apb(1, OFS_CTRL, base + 16 - 64);
    check(irq, 0);
    apb(0, OFS_STATUS, 0);
    check(rd[0], 1);
    apb(1, OFS_STATUS, 1);
    apb(0, OFS_STATUS, 0);
    check(rd[0], 0);
  endtask

  initial
  begin
    {reset_n, psel, penable, pwrite, pulseEn, srcSel} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    period = 24;
    highTime = 12;
    cycles = 0;
    seed = 32'h0000_1fdd;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(0, OFS_CTRL, 0);
    check(rd, CTRL_RESET);
    apb(0, OFS_PRESET, 0);
    check(rd, 32'h0000_0000);
    apb(0, 8'h18, 0);
    check(rd, 32'h0000_0000);
    check(lastErr, 1);
    for (int g = 0; g < 8; g++)
    begin
      seed = lfsr(seed);
      run(2, g, g % 2, g / 2 % 2, 65535 - seed[0]);
    end
    // stop rise must not land near the overflow, hence periods off multiples of 32
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      period = seed[1:0] == 2'b00 ? 24 : (seed[0] ? 28 : 36);
      run(i == 1 ? 3 : i / 2, i % 2 * 4, i % 2, (i + 1) / 2 % 2, 65535);
    end
    final_report();
  end
endmodule
`default_nettype wire
